// *** hw/ofs_selector.sv ***
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - code 4: accel needs freq >= detect; decel needs freq > detect-band/2
// - code 5: output follows motor overload
// - code 6: output follows inverse-time overload fault
// - code 7: output follows underload warning
// - code 8: output follows fan fault warning
// - code 9: output when overloaded and stalled together
// - code 10: output while DC link above overvoltage threshold
// - code 11: output while DC link below undervoltage level
// - code 12: output while inverter overheats
// - code 13: output when analog or serial command is lost
// - code 14: run command and output voltage, never during DC braking
// - code 15: run command off and no output voltage
// - code 16: steady speed, neither accelerating nor decelerating
// - code 17: motor fed from inverter line
// - code 18: motor fed from commercial mains
// - code 19: output during speed search
// - code 22: drive ready for an external run command
// - code 28: output follows the timer function
// - code 29: output after a fault trip
// - code 34: output follows analog on/off comparison
// - code 35: output follows brake release signal
// - code 40: output while energy buffering is active
// - each relay and the open collector has its own code
module ofs_selector #(
  parameter int NOUT = ofs_pkg::OFS_NOUT
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire ofs_pkg::ofs_cond_type     cond_pins,
  input  wire logic [ofs_pkg::OFS_FREQ_W-1:0] oper_freq,
  output logic                           relay1_out,
  output logic                           relay2_out,
  output logic                           open_collector_output
);

  // the pin set is fixed at three, so refuse any other count
  if (NOUT != ofs_pkg::OFS_NOUT)
  begin : g_nout_check
    $error("ofs_selector serves exactly three outputs");
  end

  localparam int CW = ofs_pkg::OFS_CODE_W;
  localparam int FW = ofs_pkg::OFS_FREQ_W;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on the condition pins; stage one feeds stage two only
  ofs_pkg::ofs_cond_type cond_meta_r;
  ofs_pkg::ofs_cond_type cond_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_meta_r <= '0;
      cond_r      <= '0;
    end
    else
    begin
      cond_meta_r <= cond_pins;
      cond_r      <= cond_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [CW-1:0] sel_r [NOUT];
  logic [FW-1:0] detf_r;
  logic [FW-1:0] band_r;
  logic [NOUT-1:0] out_r;

  // apb decode; every access completes with zero wait states
  wire wr_en    = psel & penable & pwrite;
  wire [11:0] a = paddr;
  wire hit_sel0 = (a == ofs_pkg::OFS_REG_SEL0);
  wire hit_sel1 = (a == ofs_pkg::OFS_REG_SEL1);
  wire hit_sel2 = (a == ofs_pkg::OFS_REG_SEL2);
  wire hit_detf = (a == ofs_pkg::OFS_REG_DETF);
  wire hit_band = (a == ofs_pkg::OFS_REG_BAND);
  wire hit_stat = (a == ofs_pkg::OFS_REG_STAT);
  wire hit_cond = (a == ofs_pkg::OFS_REG_COND);
  wire hit_any  = hit_sel0 | hit_sel1 | hit_sel2 | hit_detf | hit_band
                | hit_stat | hit_cond;
  wire [NOUT-1:0] hit_sel = {hit_sel2, hit_sel1, hit_sel0};

  // read mux; unused upper bits read zero
  wire [31:0] rd_mux =
      hit_sel0 ? {{(32-CW){1'b0}}, sel_r[0]} :
      hit_sel1 ? {{(32-CW){1'b0}}, sel_r[1]} :
      hit_sel2 ? {{(32-CW){1'b0}}, sel_r[2]} :
      hit_detf ? {{(32-FW){1'b0}}, detf_r} :
      hit_band ? {{(32-FW){1'b0}}, band_r} :
      hit_stat ? {{(32-NOUT){1'b0}}, out_r} :
      hit_cond ? {{(32-ofs_pkg::OFS_COND_W){1'b0}}, cond_r} :
      32'h0000_0000;

  // per-output code registers, written independently
  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_sel
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          sel_r[g] <= ofs_pkg::OFS_SEL_RST;
        else if (wr_en && hit_sel[g])
          sel_r[g] <= pwdata[CW-1:0];
      end
    end
  endgenerate

  // frequency detect settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detf_r <= ofs_pkg::OFS_DETF_RST;
      band_r <= ofs_pkg::OFS_BAND_RST;
    end
    else if (wr_en)
    begin
      if (hit_detf)
        detf_r <= pwdata[FW-1:0];
      if (hit_band)
        band_r <= pwdata[FW-1:0];
    end
  end

  // apb answer registers; unmapped addresses give pslverr, read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // freq_detect_accel_decel comparison; half band by shift, floored at zero
  wire [FW-1:0] half_band = {1'b0, band_r[FW-1:1]};
  wire [FW-1:0] dec_thr   = (detf_r > half_band) ?
                            FW'(detf_r - half_band) : '0;
  wire fdt_acc = cond_r.accelerating & (oper_freq >= detf_r);
  wire fdt_dec = cond_r.decelerating & (oper_freq > dec_thr);
  wire freq_detect_accel_decel = fdt_acc | fdt_dec;

  // derived conditions
  wire c_stall  = cond_r.motor_overload & cond_r.stall;
  wire c_run    = cond_r.run_cmd & cond_r.output_voltage
                & ~cond_r.dc_braking;
  wire c_stop   = ~cond_r.run_cmd & ~cond_r.output_voltage;
  wire c_steady = cond_r.output_voltage & ~cond_r.accelerating
                & ~cond_r.decelerating;

  // selection function, shared by all outputs
  function automatic logic pick(input logic [CW-1:0] code,
                                input ofs_pkg::ofs_cond_type c,
                                input logic fdt,
                                input logic stl,
                                input logic run,
                                input logic stp,
                                input logic sdy);
    logic v;
    v = 1'b0;
    case (code)
      ofs_pkg::OFS_F_FDT4:  v = fdt;
      ofs_pkg::OFS_F_OVLD:  v = c.motor_overload;
      ofs_pkg::OFS_F_IOL:   v = c.inverse_time_overload;
      ofs_pkg::OFS_F_UNDL:  v = c.underload_warn;
      ofs_pkg::OFS_F_FAN:   v = c.fan_warn;
      ofs_pkg::OFS_F_STALL: v = stl;
      ofs_pkg::OFS_F_OVV:   v = c.dc_overvoltage;
      ofs_pkg::OFS_F_LOWV:  v = c.dc_undervoltage;
      ofs_pkg::OFS_F_HEAT:  v = c.overheat;
      ofs_pkg::OFS_F_LOST:  v = c.cmd_lost;
      ofs_pkg::OFS_F_RUN:   v = run;
      ofs_pkg::OFS_F_STOP:  v = stp;
      ofs_pkg::OFS_F_STDY:  v = sdy;
      ofs_pkg::OFS_F_INVL:  v = c.inverter_line;
      ofs_pkg::OFS_F_COMM:  v = c.comm_line;
      ofs_pkg::OFS_F_SRCH:  v = c.speed_search;
      ofs_pkg::OFS_F_RDY:   v = c.ready;
      ofs_pkg::OFS_F_TMR:   v = c.timer_out;
      ofs_pkg::OFS_F_TRIP:  v = c.trip;
      ofs_pkg::OFS_F_ONOFF: v = c.onoff_cmp;
      ofs_pkg::OFS_F_BRK:   v = c.brake_release_drive;
      ofs_pkg::OFS_F_KEB:   v = c.energy_buffering_active;
      default:              v = 1'b0;
    endcase
    return v;
  endfunction

  // per-output selection, registered so pins come straight from flops
  logic [NOUT-1:0] out_nxt;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_out
      assign out_nxt[g] = pick(sel_r[g], cond_r, freq_detect_accel_decel,
                               c_stall, c_run, c_stop, c_steady);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_r <= '0;
    else
      out_r <= out_nxt;
  end

  // pins get their own flops, loaded from out_nxt on the same edge as out_r
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay1_out            <= 1'b0;
      relay2_out            <= 1'b0;
      open_collector_output <= 1'b0;
    end
    else
    begin
      relay1_out            <= out_nxt[0];
      relay2_out            <= out_nxt[1];
      open_collector_output <= out_nxt[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions on the selector path
  property p_fdt_accel;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ofs_pkg::OFS_F_FDT4 && cond_r.accelerating
     && !cond_r.decelerating && oper_freq >= detf_r
     && $stable(sel_r[0])) |=> relay1_out;
  endproperty
  a_fdt_accel: assert property (p_fdt_accel)
    else $error("fdt accel output missing");

  property p_overload;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[1] == ofs_pkg::OFS_F_OVLD && $stable(sel_r[1]))
      |=> (relay2_out == $past(cond_r.motor_overload));
  endproperty
  a_overload: assert property (p_overload)
    else $error("overload output wrong");

  property p_stall;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[2] == ofs_pkg::OFS_F_STALL && $stable(sel_r[2])
     && !(cond_r.motor_overload && cond_r.stall)) |=> !open_collector_output;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall output without both conditions");

  property p_run_brake;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ofs_pkg::OFS_F_RUN && cond_r.dc_braking
     && $stable(sel_r[0])) |=> !relay1_out;
  endproperty
  a_run_brake: assert property (p_run_brake)
    else $error("run output during dc braking");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[1] == ofs_pkg::OFS_F_STOP && cond_r.run_cmd
     && $stable(sel_r[1])) |=> !relay2_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop output with run command");

  property p_trip;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ofs_pkg::OFS_F_TRIP && $stable(sel_r[0]))
      |=> (relay1_out == $past(cond_r.trip));
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip output wrong");

  property p_keb;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[2] == ofs_pkg::OFS_F_KEB && $stable(sel_r[2]))
      |=> (open_collector_output == $past(cond_r.energy_buffering_active));
  endproperty
  a_keb: assert property (p_keb)
    else $error("energy buffering output wrong");

  property p_unassigned;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[1] == ofs_pkg::OFS_F_NONE && $stable(sel_r[1])) |=> !relay2_out;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("output active with code zero");

  property p_indep;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ofs_pkg::OFS_F_TRIP && sel_r[1] == ofs_pkg::OFS_F_NONE
     && cond_r.trip && $stable(sel_r[0]) && $stable(sel_r[1]))
      |=> (relay1_out && !relay2_out);
  endproperty
  a_indep: assert property (p_indep)
    else $error("outputs not independent");

  // decel side checked by addition so the floor-at-zero path is not copied
  property p_fdt_decel;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[0] == ofs_pkg::OFS_F_FDT4 && cond_r.decelerating
     && !cond_r.accelerating && oper_freq != '0
     && ({1'b0, oper_freq} + {2'b00, band_r[FW-1:1]} > {1'b0, detf_r}))
      |=> relay1_out;
  endproperty
  a_fdt_decel: assert property (p_fdt_decel)
    else $error("fdt decel output missing");

  property p_run_on;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[1] == ofs_pkg::OFS_F_RUN && cond_r.run_cmd
     && cond_r.output_voltage && !cond_r.dc_braking) |=> relay2_out;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("run output missing");

  property p_stop_on;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[2] == ofs_pkg::OFS_F_STOP && !cond_r.run_cmd
     && !cond_r.output_voltage) |=> open_collector_output;
  endproperty
  a_stop_on: assert property (p_stop_on)
    else $error("stop output missing");

  property p_steady;
    @(posedge pclk) disable iff (!presetn)
    (sel_r[1] == ofs_pkg::OFS_F_STDY
     && (cond_r.accelerating || cond_r.decelerating)) |=> !relay2_out;
  endproperty
  a_steady: assert property (p_steady)
    else $error("steady output while speed changes");

  // a trip leaving the first sync stage reaches the relay two edges later
  sequence s_trip_seen;
    cond_meta_r.trip && sel_r[0] == ofs_pkg::OFS_F_TRIP;
  endsequence
  sequence s_trip_kept;
    sel_r[0] == ofs_pkg::OFS_F_TRIP;
  endsequence
  property p_trip_latency;
    @(posedge pclk) disable iff (!presetn)
    s_trip_seen ##1 s_trip_kept |=> relay1_out;
  endproperty
  a_trip_latency: assert property (p_trip_latency)
    else $error("trip level not seen on relay in time");

endmodule
`default_nettype wire

// *** hw/ofs_pkg.sv ***
`default_nettype none
package ofs_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_REG_SEL0   = 12'h000; // relay 1 code
  localparam logic [11:0] OFS_REG_SEL1   = 12'h004; // relay 2 code
  localparam logic [11:0] OFS_REG_SEL2   = 12'h008; // open collector code
  localparam logic [11:0] OFS_REG_DETF   = 12'h00C; // detect frequency
  localparam logic [11:0] OFS_REG_BAND   = 12'h010; // detect band
  localparam logic [11:0] OFS_REG_STAT   = 12'h014; // output state
  localparam logic [11:0] OFS_REG_COND   = 12'h018; // condition snapshot
  localparam int          OFS_NOUT       = 3;
  localparam int          OFS_CODE_W     = 6;
  localparam int          OFS_FREQ_W     = 16;
  localparam logic [5:0]  OFS_SEL_RST    = 6'h00;
  localparam logic [15:0] OFS_DETF_RST   = 16'h012C; // 30.0 Hz in 0.1 Hz
  localparam logic [15:0] OFS_BAND_RST   = 16'h0064; // 10.0 Hz in 0.1 Hz

  // function codes
  typedef enum logic [5:0] {
    OFS_F_NONE  = 6'h00, OFS_F_FDT4 = 6'h04, OFS_F_OVLD  = 6'h05,
    OFS_F_IOL   = 6'h06, OFS_F_UNDL = 6'h07, OFS_F_FAN   = 6'h08,
    OFS_F_STALL = 6'h09, OFS_F_OVV  = 6'h0A, OFS_F_LOWV  = 6'h0B,
    OFS_F_HEAT  = 6'h0C, OFS_F_LOST = 6'h0D, OFS_F_RUN   = 6'h0E,
    OFS_F_STOP  = 6'h0F, OFS_F_STDY = 6'h10, OFS_F_INVL  = 6'h11,
    OFS_F_COMM  = 6'h12, OFS_F_SRCH = 6'h13, OFS_F_RDY   = 6'h16,
    OFS_F_TMR   = 6'h1C, OFS_F_TRIP = 6'h1D, OFS_F_ONOFF = 6'h22,
    OFS_F_BRK   = 6'h23, OFS_F_KEB  = 6'h28
  } ofs_code_type;

  // drive status inputs, each a level from other logic or pins
  typedef struct packed {
    logic motor_overload;
    logic inverse_time_overload;
    logic underload_warn;
    logic fan_warn;
    logic stall;
    logic dc_overvoltage;
    logic dc_undervoltage;
    logic overheat;
    logic cmd_lost;
    logic run_cmd;
    logic output_voltage;
    logic dc_braking;
    logic accelerating;
    logic decelerating;
    logic inverter_line;
    logic comm_line;
    logic speed_search;
    logic ready;
    logic timer_out;
    logic trip;
    logic onoff_cmp;
    logic brake_release_drive;
    logic energy_buffering_active;
  } ofs_cond_type;
  localparam int OFS_COND_W = $bits(ofs_cond_type);
endpackage
`default_nettype wire

// *** testbench/ofs_out_model.sv ***
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ofs_out_model (
  input  wire logic relay1_out,
  input  wire logic relay2_out,
  input  wire logic open_collector_output,
  output logic      relay1_closed,
  output logic      relay2_closed,
  output logic      oc_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // relay coils close their contacts only while energised
  assign relay1_closed = relay1_out;
  assign relay2_closed = relay2_out;
  // transistor sinks a pulled-up line; when off the pull-up wins, not x
  assign oc_line_n = open_collector_output ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** testbench/output_function_selector_tb_top.sv ***
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module output_function_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, r1, r2, oc, c1, c2, ocn;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [15:0] freq = 16'h0000;
  ofs_pkg::ofs_cond_type cond = '0;
  int errors = 0, checks = 0;
  // masks of single conditions, msb is motor overload
  localparam logic [22:0] OVL = 23'h400000, STL = 23'h040000;
  localparam logic [22:0] RUN = 23'h002000, VLT = 23'h001000;
  localparam logic [22:0] DCB = 23'h000800, ACC = 23'h000400;
  localparam logic [22:0] DEC = 23'h000200, ALL = 23'h7FFFFF;
  always #5 pclk = ~pclk;

  ofs_selector DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cond_pins(cond), .oper_freq(freq), .relay1_out(r1),
    .relay2_out(r2), .open_collector_output(oc));
  ofs_out_model model (.relay1_out(r1), .relay2_out(r2),
    .open_collector_output(oc), .relay1_closed(c1),
    .relay2_closed(c2), .oc_line_n(ocn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    chk("access cycles", 32'h1, 32'(n));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic er);
    logic [31:0] q;
    logic x;
    apb(1'b0, a, 32'h0, q, x);
    chk("read data", e, q);
    chk("pslverr", {31'h0, er}, {31'h0, x});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic x;
    apb(1'b1, a, d, q, x);
  endtask

  // same code on all three outputs, then drive conditions and compare
  task automatic sel(input logic [5:0] code, input logic [22:0] c,
                     input logic [15:0] f, input logic e);
    wr(ofs_pkg::OFS_REG_SEL0, {26'h0, code});
    wr(ofs_pkg::OFS_REG_SEL1, {26'h0, code});
    wr(ofs_pkg::OFS_REG_SEL2, {26'h0, code});
    cond <= c;
    freq <= f;
    repeat (5) @(posedge pclk);
    chk("outputs", {29'h0, {3{e}}}, {29'h0, c1, c2, ~ocn});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk("outputs after reset", 32'h0, {29'h0, r1, r2, oc});
    rd(ofs_pkg::OFS_REG_SEL0, 32'h0, 1'b0);
    rd(ofs_pkg::OFS_REG_SEL2, 32'h0, 1'b0);
    rd(ofs_pkg::OFS_REG_DETF, 32'h0000012C, 1'b0);
    rd(ofs_pkg::OFS_REG_BAND, 32'h00000064, 1'b0);
    wr(ofs_pkg::OFS_REG_SEL1, 32'h00000016);
    rd(ofs_pkg::OFS_REG_SEL1, 32'h00000016, 1'b0);
    rd(12'h01C, 32'h0, 1'b1);
    $display("test regs done");
  endtask

  // codes that follow one condition: on alone, off with all others on
  task automatic t_single;
    logic [5:0] cd [17] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h0A, 6'h0B,
      6'h0C, 6'h0D, 6'h11, 6'h12, 6'h13, 6'h16, 6'h1C, 6'h1D, 6'h22,
      6'h23, 6'h28};
    int bt [17] = '{22, 21, 20, 19, 17, 16, 15, 14, 8, 7, 6, 5, 4, 3, 2,
      1, 0};
    for (int i = 0; i < 17; i++)
    begin
      sel(cd[i], 23'h1 << bt[i], 16'h0000, 1'b1);
      sel(cd[i], ALL ^ (23'h1 << bt[i]), 16'h0000, 1'b0);
    end
    $display("test single done");
  endtask

  task automatic t_combo;
    sel(6'h04, ACC, 16'h012C, 1'b1);
    sel(6'h04, ACC, 16'h012B, 1'b0);
    sel(6'h04, DEC, 16'h00FB, 1'b1);
    sel(6'h04, DEC, 16'h00FA, 1'b0);
    // threshold floors at zero once half the band reaches the detect point
    wr(ofs_pkg::OFS_REG_DETF, 32'h00000064);
    wr(ofs_pkg::OFS_REG_BAND, 32'h000000C8);
    rd(ofs_pkg::OFS_REG_DETF, 32'h00000064, 1'b0);
    sel(6'h04, DEC, 16'h0001, 1'b1);
    sel(6'h04, DEC, 16'h0000, 1'b0);
    sel(6'h04, ACC, 16'h0064, 1'b1);
    sel(6'h09, OVL, 16'h0000, 1'b0);
    sel(6'h09, STL, 16'h0000, 1'b0);
    sel(6'h09, OVL | STL, 16'h0000, 1'b1);
    sel(6'h0E, RUN | VLT, 16'h0000, 1'b1);
    sel(6'h0E, RUN | VLT | DCB, 16'h0000, 1'b0);
    sel(6'h0E, RUN, 16'h0000, 1'b0);
    sel(6'h0F, 23'h0, 16'h0000, 1'b1);
    sel(6'h0F, RUN, 16'h0000, 1'b0);
    sel(6'h0F, VLT, 16'h0000, 1'b0);
    sel(6'h10, VLT, 16'h0000, 1'b1);
    sel(6'h10, VLT | ACC, 16'h0000, 1'b0);
    sel(6'h10, VLT | DEC, 16'h0000, 1'b0);
    sel(6'h1F, ALL, 16'hFFFF, 1'b0);
    sel(6'h00, ALL, 16'hFFFF, 1'b0);
    sel(6'h3F, ALL, 16'hFFFF, 1'b0);
    $display("test combo done");
  endtask

  // each output follows its own code
  task automatic t_indep;
    wr(ofs_pkg::OFS_REG_SEL0, 32'h00000005);
    wr(ofs_pkg::OFS_REG_SEL1, 32'h00000006);
    wr(ofs_pkg::OFS_REG_SEL2, 32'h00000016);
    cond <= OVL | 23'h000020;
    repeat (5) @(posedge pclk);
    chk("outputs", 32'h5, {29'h0, c1, c2, ~ocn});
    rd(ofs_pkg::OFS_REG_STAT, 32'h5, 1'b0);
    rd(ofs_pkg::OFS_REG_COND, 32'h00400020, 1'b0);
    wr(ofs_pkg::OFS_REG_SEL0, 32'h0000001D);
    wr(ofs_pkg::OFS_REG_SEL1, 32'h00000000);
    cond <= 23'h000008;
    repeat (5) @(posedge pclk);
    chk("outputs", 32'h4, {29'h0, c1, c2, ~ocn});
    $display("test indep done");
  endtask

  // reset in mid-run clears codes and outputs, then pins resync
  task automatic t_reset;
    presetn <= 1'b0;
    @(posedge pclk);
    chk("outputs in reset", 32'h0, {29'h0, r1, r2, oc});
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ofs_pkg::OFS_REG_SEL0, 32'h0, 1'b0);
    rd(ofs_pkg::OFS_REG_COND, 32'h00000008, 1'b0);
    chk("outputs after reset", 32'h0, {29'h0, r1, r2, oc});
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence after a three cycle reset
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_single();
    t_combo();
    t_indep();
    t_reset();
    test_done();
  end

  // watchdog well beyond the roughly 1000 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
